/* inc/rx_buffer_pkg.sv */
// Constants shared by the receive buffer and status logic.
// Notes on behaviour
// - Ninth bit and error flags stored per entry.
// - Complete flag is one while unread frames exist.
// - Receiver disable flushes buffer, clears complete flag.
// - Interrupt follows complete flag when both enables set.
// - Visible error flags follow buffer read position.
// - Software writes never change error flags.
// - Error flags never raise interrupts.
// - Frame error equals inverted first stop bit.
// - Only first stop bit checked, count ignored.
// - Overrun: buffer full, char waiting, new start.
// - Overrun cleared on successful transfer into buffer.
// - Parity checked when enabled; odd/even selectable.
// - Parity error stored only if checking enabled.
// - Parity error reads zero while checking disabled.
// - Disable is immediate, aborts frame, releases pin.
// - Frame moved at first stop bit, second ignored.
// - Unused upper data bits read as zero.
// - Enable activates receiver and takes receive pin.
package rx_buffer_pkg;

	// Buffer geometry.
	localparam int unsigned FIFO_DEPTH = 2;
	localparam int unsigned PTR_W = 1;
	localparam int unsigned COUNT_W = 2;
	localparam logic [1:0] COUNT_FULL = 2'h2;
	localparam logic [1:0] COUNT_EMPTY = 2'h0;

	// Layout of one buffer entry.
	localparam int unsigned DATA_W = 9;
	localparam int unsigned HOLD_W = 11;
	localparam int unsigned ENTRY_W = 12;
	localparam int unsigned NINTH_POS = 8;
	localparam int unsigned FRAME_ERR_POS = 9;
	localparam int unsigned PARITY_ERR_POS = 10;
	localparam int unsigned OVERRUN_POS = 11;

	// Character size codes.
	localparam logic [2:0] CHAR_SIZE_5 = 3'h0;
	localparam logic [2:0] CHAR_SIZE_6 = 3'h1;
	localparam logic [2:0] CHAR_SIZE_7 = 3'h2;
	localparam logic [2:0] CHAR_SIZE_8 = 3'h3;
	localparam logic [2:0] CHAR_SIZE_9 = 3'h7;

	// Reset values.
	localparam logic [ENTRY_W-1:0] ENTRY_RESET = 12'h000;
	localparam logic [HOLD_W-1:0] HOLD_RESET = 11'h000;
	localparam logic [PTR_W-1:0] PTR_RESET = 1'h0;

	// State of the shift register's finished character.
	typedef enum logic [1:0] {
		HOLD_EMPTY = 2'h1,
		HOLD_FULL = 2'h2
	} hold_state_t;

endpackage

/* verilog/rx_fifo_mem.sv */
// Two-entry receive buffer storage with a registered read port.
`timescale 1ns/10ps
module rx_fifo_mem
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Write port.
	input wire logic wr_en_i,
	input wire logic [rx_buffer_pkg::PTR_W-1:0] wr_addr_i,
	input wire logic [rx_buffer_pkg::ENTRY_W-1:0] wr_data_i,
	// Read port.
	input wire logic [rx_buffer_pkg::PTR_W-1:0] rd_addr_i,
	input wire logic rd_valid_i,
	output logic [rx_buffer_pkg::ENTRY_W-1:0] rd_data_o
);

	logic [rx_buffer_pkg::ENTRY_W-1:0] entry_q [rx_buffer_pkg::FIFO_DEPTH];
	logic [rx_buffer_pkg::ENTRY_W-1:0] entry_d [rx_buffer_pkg::FIFO_DEPTH];
	logic [rx_buffer_pkg::ENTRY_W-1:0] rd_q;
	logic [rx_buffer_pkg::ENTRY_W-1:0] rd_d;

	genvar i;
	generate
		for (i = 0; i < rx_buffer_pkg::FIFO_DEPTH; i++)
		begin : g_entry
			always_comb
			begin
				entry_d[i] = entry_q[i];
				if (wr_en_i && (int'(wr_addr_i) == i))
				begin
					entry_d[i] = wr_data_i;
				end
			end

			always_ff @(posedge clock_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					entry_q[i] <= rx_buffer_pkg::ENTRY_RESET;
				end
				else
				begin
					entry_q[i] <= entry_d[i];
				end
			end
		end
	endgenerate

	// The read register looks at the next contents, so while rd_valid_i is set the output
	// shows the entry at the read position without a cycle of lag, and zero otherwise.
	always_comb
	begin
		rd_d = rx_buffer_pkg::ENTRY_RESET;
		if (rd_valid_i)
		begin
			rd_d = entry_d[rd_addr_i];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_q <= rx_buffer_pkg::ENTRY_RESET;
		end
		else
		begin
			rd_q <= rd_d;
		end
	end

	assign rd_data_o = rd_q;

endmodule

/* verilog/rx_parity_check.sv */
// Data masking by character size and parity check of a received frame.
`timescale 1ns/10ps
module rx_parity_check
(
	// Frame from the shift register.
	input wire logic [rx_buffer_pkg::DATA_W-1:0] data_i,
	input wire logic parity_bit_i,
	// Configuration.
	input wire logic [2:0] char_size_field_i,
	input wire logic parity_odd_select_i,
	// Results.
	output logic [rx_buffer_pkg::DATA_W-1:0] masked_o,
	output logic mismatch_o
);

	logic [rx_buffer_pkg::DATA_W-1:0] mask;

	always_comb
	begin
		case (char_size_field_i)
			rx_buffer_pkg::CHAR_SIZE_5: mask = 9'h01F;
			rx_buffer_pkg::CHAR_SIZE_6: mask = 9'h03F;
			rx_buffer_pkg::CHAR_SIZE_7: mask = 9'h07F;
			rx_buffer_pkg::CHAR_SIZE_9: mask = 9'h1FF;
			default: mask = 9'h0FF;
		endcase
	end

	assign masked_o = data_i & mask;
	// Even parity expects the bit to make the ones count even; odd flips it.
	assign mismatch_o = (^masked_o) ^ parity_odd_select_i ^ parity_bit_i;

endmodule

/* verilog/uart_receive_buffer_status.sv */
// Receive buffer, error flags, complete flag and interrupt of the serial receiver.
`timescale 1ns/10ps
module uart_receive_buffer_status
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_i,
	// Configuration bits.
	input wire logic receiver_enable_bit_i,
	input wire logic parity_enable_bit_i,
	input wire logic parity_odd_select_i,
	input wire logic [2:0] char_size_field_i,
	input wire logic rx_complete_irq_enable_i,
	input wire logic global_irq_enable_i,
	// Receive shift register side.
	input wire logic start_detect_i,
	input wire logic frame_done_i,
	input wire logic [rx_buffer_pkg::DATA_W-1:0] frame_data_i,
	input wire logic frame_parity_i,
	input wire logic first_stop_i,
	output logic rx_abort_o,
	output logic rx_pin_select_o,
	// Software read of the data location.
	input wire logic data_read_i,
	output logic [7:0] rx_data_o,
	output logic rx_ninth_bit_o,
	// Status and interrupt.
	output logic frame_error_flag_o,
	output logic data_overrun_flag_o,
	output logic parity_error_flag_o,
	output logic rx_complete_flag_o,
	output logic rx_complete_irq_o
);

	// Buffer pointers and fill level.
	logic [rx_buffer_pkg::PTR_W-1:0] rd_ptr_q;
	logic [rx_buffer_pkg::PTR_W-1:0] rd_ptr_d;
	logic [rx_buffer_pkg::PTR_W-1:0] wr_ptr_q;
	logic [rx_buffer_pkg::PTR_W-1:0] wr_ptr_d;
	logic [rx_buffer_pkg::COUNT_W-1:0] count_q;
	logic [rx_buffer_pkg::COUNT_W-1:0] count_d;

	// Finished character waiting in the shift register.
	rx_buffer_pkg::hold_state_t hold_state_q;
	rx_buffer_pkg::hold_state_t hold_state_d;
	logic [rx_buffer_pkg::HOLD_W-1:0] hold_q;
	logic [rx_buffer_pkg::HOLD_W-1:0] hold_d;
	logic overrun_q;
	logic overrun_d;

	// Combinational helpers.
	logic [rx_buffer_pkg::DATA_W-1:0] masked_data;
	logic parity_mismatch;
	logic [rx_buffer_pkg::HOLD_W-1:0] new_frame;
	logic [rx_buffer_pkg::HOLD_W-1:0] push_frame;
	logic [rx_buffer_pkg::ENTRY_W-1:0] push_entry;
	logic [rx_buffer_pkg::ENTRY_W-1:0] head_entry;
	logic do_read;
	logic slot_free;
	logic push;
	logic overrun_event;
	logic head_valid;

	rx_parity_check u_parity
	(
		.data_i(frame_data_i),
		.parity_bit_i(frame_parity_i),
		.char_size_field_i(char_size_field_i),
		.parity_odd_select_i(parity_odd_select_i),
		.masked_o(masked_data),
		.mismatch_o(parity_mismatch)
	);

	// Pack a finished character with its status as it leaves the shift
	// register: stop bit sense, parity result and the masked data.
	always_comb
	begin
		new_frame = rx_buffer_pkg::HOLD_RESET;
		new_frame[rx_buffer_pkg::DATA_W-1:0] = masked_data;
		if (char_size_field_i != rx_buffer_pkg::CHAR_SIZE_9)
		begin
			new_frame[rx_buffer_pkg::NINTH_POS] = 1'b0;
		end
		// Only the first stop bit is presented; the stop count is not used.
		new_frame[rx_buffer_pkg::FRAME_ERR_POS] = ~first_stop_i;
		// The check result is frozen with the frame, using the enable of
		// that moment, so later changes of the enable do not rewrite it.
		new_frame[rx_buffer_pkg::PARITY_ERR_POS] = parity_enable_bit_i & parity_mismatch;
	end

	// A read of an empty buffer is ignored.
	assign do_read = data_read_i & (count_q != rx_buffer_pkg::COUNT_EMPTY);
	assign slot_free = (count_q != rx_buffer_pkg::COUNT_FULL) | do_read;

	// Overrun: both slots taken, a finished character waits in the shift
	// register and a new start bit begins to overwrite it.
	assign overrun_event = start_detect_i & receiver_enable_bit_i
		& (count_q == rx_buffer_pkg::COUNT_FULL) & ~do_read
		& (hold_state_q == rx_buffer_pkg::HOLD_FULL);

	// Holding register: a finished character that found both slots taken
	// waits here, and unless an overrun or a disable drops it, it enters the buffer ahead of anything newer.
	always_comb
	begin
		hold_state_d = hold_state_q;
		hold_d = hold_q;
		push = 1'b0;
		push_frame = new_frame;
		if (!receiver_enable_bit_i)
		begin
			// Disable is immediate: a character still waiting is lost too.
			hold_state_d = rx_buffer_pkg::HOLD_EMPTY;
			hold_d = rx_buffer_pkg::HOLD_RESET;
		end
		else
		begin
			case (hold_state_q)
				rx_buffer_pkg::HOLD_FULL:
				begin
					if (slot_free)
					begin
						// The waiting character moves first to keep order.
						push = 1'b1;
						push_frame = hold_q;
						if (frame_done_i)
						begin
							hold_d = new_frame;
						end
						else
						begin
							hold_state_d = rx_buffer_pkg::HOLD_EMPTY;
						end
					end
					else if (overrun_event)
					begin
						// The waiting character is overwritten by the new one.
						hold_state_d = rx_buffer_pkg::HOLD_EMPTY;
					end
					else if (frame_done_i)
					begin
						hold_d = new_frame;
					end
				end
				rx_buffer_pkg::HOLD_EMPTY:
				begin
					if (frame_done_i)
					begin
						if (slot_free)
						begin
							push = 1'b1;
						end
						else
						begin
							hold_state_d = rx_buffer_pkg::HOLD_FULL;
							hold_d = new_frame;
						end
					end
				end
				default:
				begin
					// A corrupted state code drops the character rather than lock up.
					hold_state_d = rx_buffer_pkg::HOLD_EMPTY;
				end
			endcase
		end
	end

	// Registers of the holding stage.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			hold_state_q <= rx_buffer_pkg::HOLD_EMPTY;
			hold_q <= rx_buffer_pkg::HOLD_RESET;
		end
		else
		begin
			hold_state_q <= hold_state_d;
			hold_q <= hold_d;
		end
	end

	// Buffer pointers and fill level.
	always_comb
	begin
		rd_ptr_d = rd_ptr_q;
		wr_ptr_d = wr_ptr_q;
		count_d = count_q;
		if (!receiver_enable_bit_i)
		begin
			// Unread frames are discarded by emptying the pointers.
			rd_ptr_d = rx_buffer_pkg::PTR_RESET;
			wr_ptr_d = rx_buffer_pkg::PTR_RESET;
			count_d = rx_buffer_pkg::COUNT_EMPTY;
		end
		else
		begin
			if (do_read)
			begin
				rd_ptr_d = rd_ptr_q + 1'b1;
			end
			if (push)
			begin
				wr_ptr_d = wr_ptr_q + 1'b1;
			end
			// A push and a read in one cycle leave the level unchanged.
			case ({push, do_read})
				2'h2: count_d = count_q + 2'h1;
				2'h1: count_d = count_q - 2'h1;
				default: count_d = count_q;
			endcase
		end
	end

	// Registers of the pointers and the fill level.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_ptr_q <= rx_buffer_pkg::PTR_RESET;
			wr_ptr_q <= rx_buffer_pkg::PTR_RESET;
			count_q <= rx_buffer_pkg::COUNT_EMPTY;
		end
		else
		begin
			rd_ptr_q <= rd_ptr_d;
			wr_ptr_q <= wr_ptr_d;
			count_q <= count_d;
		end
	end

	// Loss marker: set by an overrun and carried by the next frame that
	// enters the buffer; a new overrun in the same cycle as a transfer wins.
	always_comb
	begin
		overrun_d = overrun_q;
		if (!receiver_enable_bit_i)
		begin
			overrun_d = 1'b0;
		end
		else if (overrun_event)
		begin
			overrun_d = 1'b1;
		end
		else if (push)
		begin
			overrun_d = 1'b0;
		end
	end

	// Register of the loss marker.
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			overrun_q <= 1'b0;
		end
		else
		begin
			overrun_q <= overrun_d;
		end
	end

	// The entry written carries the loss marker of frames dropped before it.
	always_comb
	begin
		push_entry = {overrun_q, push_frame};
	end

	// The read register loads from the next state, so the head shows the
	// entry at the read position with no extra cycle of lag.
	assign head_valid = count_d != rx_buffer_pkg::COUNT_EMPTY;

	rx_fifo_mem u_mem
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.wr_en_i(push),
		.wr_addr_i(wr_ptr_q),
		.wr_data_i(push_entry),
		.rd_addr_i(rd_ptr_d),
		.rd_valid_i(head_valid),
		.rd_data_o(head_entry)
	);

	// Data, ninth bit and error flags belong to the entry at the read position; there is
	// no write path into the flags, so software cannot alter them.
	assign rx_data_o = head_entry[7:0];
	assign rx_ninth_bit_o = head_entry[rx_buffer_pkg::NINTH_POS];
	assign frame_error_flag_o = head_entry[rx_buffer_pkg::FRAME_ERR_POS];
	assign data_overrun_flag_o = head_entry[rx_buffer_pkg::OVERRUN_POS];
	// Gated by the live enable so a stale result never shows once the
	// checker is switched off.
	assign parity_error_flag_o = head_entry[rx_buffer_pkg::PARITY_ERR_POS]
		& parity_enable_bit_i;
	assign rx_complete_flag_o = count_q != rx_buffer_pkg::COUNT_EMPTY;

	// A level request, not a pulse: it stays until the buffer drains.
	// The error flags take no part in it.
	assign rx_complete_irq_o = rx_complete_flag_o & rx_complete_irq_enable_i
		& global_irq_enable_i;

	// Shift register control and pin ownership.
	assign rx_abort_o = ~receiver_enable_bit_i;
	assign rx_pin_select_o = receiver_enable_bit_i;

endmodule

/* sim/uart_receive_buffer_status_chk.sv */
// Port-level checks of the receive buffer and status block.
`timescale 1ns/10ps
module uart_receive_buffer_status_chk
(
	// Clock, reset and configuration.
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic receiver_enable_bit_i,
	input wire logic parity_enable_bit_i,
	input wire logic rx_complete_irq_enable_i,
	input wire logic global_irq_enable_i,
	// Frame and read strobes.
	input wire logic frame_done_i,
	input wire logic first_stop_i,
	input wire logic data_read_i,
	// Outputs watched.
	input wire logic rx_abort_o,
	input wire logic rx_pin_select_o,
	input wire logic [7:0] rx_data_o,
	input wire logic rx_ninth_bit_o,
	input wire logic frame_error_flag_o,
	input wire logic data_overrun_flag_o,
	input wire logic parity_error_flag_o,
	input wire logic rx_complete_flag_o,
	input wire logic rx_complete_irq_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	a_irq_follows_flag: assert property (
		rx_complete_irq_o == (rx_complete_flag_o && rx_complete_irq_enable_i &&
		global_irq_enable_i)) else $error("irq does not follow complete flag");
	a_abort_on_disable: assert property (
		rx_abort_o == !receiver_enable_bit_i) else $error("abort wrong");
	a_pin_takeover: assert property (
		rx_pin_select_o == receiver_enable_bit_i) else $error("pin select wrong");
	a_disable_flushes: assert property (
		!receiver_enable_bit_i |=> !rx_complete_flag_o) else $error("no flush");
	a_frame_sets_flag: assert property (
		frame_done_i && receiver_enable_bit_i |=> rx_complete_flag_o)
		else $error("frame not buffered");
	a_parity_off_zero: assert property (
		!parity_enable_bit_i |-> !parity_error_flag_o) else $error("parity flag set");
	a_empty_reads_zero: assert property (
		!rx_complete_flag_o |-> rx_data_o == 8'h00 && !rx_ninth_bit_o &&
		!frame_error_flag_o && !data_overrun_flag_o) else $error("empty head not zero");
	a_stop_sets_error: assert property (
		frame_done_i && receiver_enable_bit_i && !rx_complete_flag_o |=>
		frame_error_flag_o == !$past(first_stop_i)) else $error("frame error wrong");
	a_head_holds: assert property (
		rx_complete_flag_o && !data_read_i && receiver_enable_bit_i |=>
		$stable(rx_data_o) && $stable(frame_error_flag_o) && $stable(data_overrun_flag_o))
		else $error("head moved without read");
	c_frame_in: cover property (frame_done_i && !rx_complete_flag_o);
	c_overrun: cover property ($rose(data_overrun_flag_o));
	c_irq: cover property (rx_complete_irq_o);
endmodule
bind uart_receive_buffer_status uart_receive_buffer_status_chk chk_u (.*);

/* sim/rx_line_model.sv */
// Remote transmitter as seen through the receiver's shift logic.
`timescale 1ns/10ps
module rx_line_model
(
	// Clock and link parity sense.
	input wire logic clock_i,
	input wire logic odd_i,
	// Towards the receive buffer.
	output logic start_detect_o,
	output logic frame_done_o,
	output logic [8:0] frame_data_o,
	output logic parity_o,
	output logic first_stop_o
);
	initial
	begin
		start_detect_o = 1'b0;
		frame_done_o = 1'b0;
		frame_data_o = 9'h000;
		parity_o = 1'b0;
		first_stop_o = 1'b1;
	end
	// After each done pulse the lines carry inverted values, so stale data cannot match.
	task automatic send(input logic [8:0] word, input logic stop, input logic flip);
		start_detect_o = 1'b1;
		@(posedge clock_i);
		#1;
		start_detect_o = 1'b0;
		frame_done_o = 1'b1;
		frame_data_o = word;
		parity_o = ^word ^ odd_i ^ flip;
		first_stop_o = stop;
		@(posedge clock_i);
		#1;
		frame_done_o = 1'b0;
		frame_data_o = ~word;
		parity_o = ~parity_o;
		first_stop_o = ~stop;
	endtask
endmodule

/* sim/uart_receive_buffer_status_tb_top.sv */
// Self-checking bench for the receive buffer and status block.
`timescale 1ns/10ps
module uart_receive_buffer_status_tb_top;
	logic clock_i, rst_i, receiver_enable_bit_i, parity_enable_bit_i, parity_odd_select_i;
	logic rx_complete_irq_enable_i, global_irq_enable_i, data_read_i;
	logic start_detect_i, frame_done_i, frame_parity_i, first_stop_i, rx_abort_o;
	logic rx_pin_select_o, rx_ninth_bit_o, frame_error_flag_o, data_overrun_flag_o;
	logic parity_error_flag_o, rx_complete_flag_o, rx_complete_irq_o;
	logic [2:0] char_size_field_i;
	logic [8:0] frame_data_i;
	logic [7:0] rx_data_o;
	int bad_count;
	int tests_run;
	uart_receive_buffer_status dut_u (.*);
	rx_line_model line_u (.clock_i(clock_i), .odd_i(parity_odd_select_i),
		.start_detect_o(start_detect_i), .frame_done_o(frame_done_i),
		.frame_data_o(frame_data_i), .parity_o(frame_parity_i), .first_stop_o(first_stop_i));
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		tests_run++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Expected layout: complete, ninth, frame error, overrun, parity error, data.
	task automatic head(input logic [12:0] exp);
		chk("head", exp, {rx_complete_flag_o, rx_ninth_bit_o, frame_error_flag_o,
			data_overrun_flag_o, parity_error_flag_o, rx_data_o});
	endtask
	task automatic tx(input logic [8:0] w, input logic stop, input logic flip);
		line_u.send(w, stop, flip);
		tick(1);
	endtask
	task automatic pop;
		data_read_i = 1'b1;
		tick(1);
		data_read_i = 1'b0;
		tick(1);
	endtask
	task automatic t_sizes;
		// The last code is unassigned and must behave as eight bits.
		logic [2:0] code [6] = '{rx_buffer_pkg::CHAR_SIZE_5, rx_buffer_pkg::CHAR_SIZE_6,
			rx_buffer_pkg::CHAR_SIZE_7, rx_buffer_pkg::CHAR_SIZE_8, rx_buffer_pkg::CHAR_SIZE_9,
			3'h4};
		logic [8:0] m [6] = '{9'h01F, 9'h03F, 9'h07F, 9'h0FF, 9'h1FF, 9'h0FF};
		for (int i = 0; i < 6; i++)
		begin
			char_size_field_i = code[i];
			tx(9'h1AB, 1'b1, 1'b0);
			head({1'b1, m[i][8], 3'h0, 8'hAB & m[i][7:0]});
			pop();
			head(13'h0000);
		end
		char_size_field_i = rx_buffer_pkg::CHAR_SIZE_8;
		$display("test sizes done");
	endtask
	task automatic t_errors;
		parity_enable_bit_i = 1'b1;
		parity_odd_select_i = 1'b1;
		tx(9'h055, 1'b0, 1'b0);
		tx(9'h0C3, 1'b1, 1'b1);
		tx(9'h011, 1'b1, 1'b0);
		head({1'b1, 4'h4, 8'h55});
		pop();
		head({1'b1, 4'h1, 8'hC3});
		parity_enable_bit_i = 1'b0;
		#1;
		head({1'b1, 4'h0, 8'hC3});
		parity_enable_bit_i = 1'b1;
		pop();
		head({1'b1, 4'h0, 8'h11});
		pop();
		parity_odd_select_i = 1'b0;
		tx(9'h0C3, 1'b1, 1'b0);
		head({1'b1, 4'h0, 8'hC3});
		pop();
		parity_enable_bit_i = 1'b0;
		tx(9'h0C3, 1'b1, 1'b1);
		parity_enable_bit_i = 1'b1;
		#1;
		head({1'b1, 4'h0, 8'hC3});
		pop();
		$display("test errors done");
	endtask
	task automatic t_overrun;
		tx(9'h001, 1'b1, 1'b0);
		tx(9'h002, 1'b1, 1'b0);
		tx(9'h003, 1'b1, 1'b0);
		tx(9'h004, 1'b1, 1'b0);
		head({1'b1, 4'h0, 8'h01});
		pop();
		head({1'b1, 4'h0, 8'h02});
		pop();
		head({1'b1, 4'h2, 8'h04});
		pop();
		head(13'h0000);
		tx(9'h005, 1'b1, 1'b0);
		head({1'b1, 4'h0, 8'h05});
		pop();
		$display("test overrun done");
	endtask
	task automatic t_irq;
		rx_complete_irq_enable_i = 1'b1;
		global_irq_enable_i = 1'b1;
		tx(9'h021, 1'b1, 1'b0);
		chk("irq", 13'h0001, rx_complete_irq_o);
		global_irq_enable_i = 1'b0;
		#1;
		chk("irq", 13'h0000, rx_complete_irq_o);
		global_irq_enable_i = 1'b1;
		tx(9'h022, 1'b1, 1'b0);
		receiver_enable_bit_i = 1'b0;
		#1;
		chk("pins", 13'h0002, {rx_abort_o, rx_pin_select_o});
		tick(1);
		head(13'h0000);
		chk("irq", 13'h0000, rx_complete_irq_o);
		tx(9'h023, 1'b1, 1'b0);
		head(13'h0000);
		receiver_enable_bit_i = 1'b1;
		#1;
		chk("pins", 13'h0001, {rx_abort_o, rx_pin_select_o});
		tx(9'h024, 1'b1, 1'b0);
		head({1'b1, 4'h0, 8'h24});
		pop();
		chk("irq", 13'h0000, rx_complete_irq_o);
		$display("test irq done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		bad_count = 0;
		tests_run = 0;
		rst_i = 1'b1;
		receiver_enable_bit_i = 1'b1;
		parity_enable_bit_i = 1'b0;
		parity_odd_select_i = 1'b0;
		char_size_field_i = rx_buffer_pkg::CHAR_SIZE_8;
		rx_complete_irq_enable_i = 1'b0;
		global_irq_enable_i = 1'b0;
		// No status write is ever issued, so flags only change through received frames, reads, the receiver enable and the parity enable.
		data_read_i = 1'b0;
		tick(2);
		rst_i = 1'b0;
		tick(1);
		head(13'h0000);
		t_sizes();
		t_errors();
		t_overrun();
		t_irq();
		final_report();
	end
	// The tests need about 100 cycles; this leaves ample margin.
	initial
	begin
		#20000;
		bad_count++;
		final_report();
	end
endmodule
